/* File: rtl/pcc_top.sv */
// Purpose: capture/compare/pwm unit with apb register access
// Assumes: clk is the system clock; capture_timebase on the same clock
// Notes:   zero-wait apb slave, read data registered in the setup cycle
// How it works
// - wrap on limit: clear counter, set pin unless new duty is zero, latch duty
// - duty is high byte plus two low bits
// - duty writes apply at next period wrap
// - shadow duty is read-only in pwm mode
// - time base appends clock phase or prescaler bits
// - time base equals shadow duty: pin cleared
// - period is limit plus one, times four, times prescale
// - postscaler never affects pwm period
// - duty beyond period: pin left unchanged
// - sleep freezes counter, state and pin
// - reset: pin input, registers to defaults
// - mode zero resets unit; 0001, 0011 reserved
// - capture modes: fall, rise, every 4th, 16th
// - compare toggle, set, clear; set/clear raise flag
// - software-interrupt compare leaves pin undriven
// - special trigger: flag, timebase reset, converter start
// - mode 11xx is pwm
// - duty low bits ignored outside pwm
// - control cleared: pin released, output latch low
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/10ps
module pcc_top (
  input  wire logic        clk,              // system clock, 250 MHz
  input  wire logic        rst_n,            // sync reset, active low
  input  wire logic        psel,             // apb select
  input  wire logic        penable,          // apb access phase
  input  wire logic        pwrite,           // apb write
  input  wire logic [7:0]  paddr,            // apb byte address
  input  wire logic [31:0] pwdata,           // apb write data
  output logic      [31:0] prdata,           // apb read data
  output logic             pready,           // apb ready
  output logic             pslverr,          // apb error, unmapped
  input  wire logic        sleep,            // device sleep
  input  wire logic [15:0] capture_timebase, // capture/compare timer
  input  wire logic        adc_enable,       // converter enabled
  input  wire logic        pin_in,           // unit pin, input side
  output logic             pin_out,          // unit pin, output side
  output logic             pin_oe,           // unit pin drive enable
  output logic             timebase_reset,   // special trigger pulse
  output logic             adc_start         // conversion start pulse
);
  logic [7:0]          mode_q;
  logic [7:0]          dhi_q;
  logic [7:0]          shd_q;
  logic [1:0]          latch_q;
  logic [7:0]          per_q;
  pcc_pkg::pcc_tctl_t  tctl_q;
  logic [1:0]          flag_q;
  logic                dir_q;
  logic                pin_q;
  logic                cmp_q;
  logic [3:0]          mode;
  logic                pwm;
  logic                cmp_mode;
  logic                wr;
  logic [7:0]          wb;
  logic [7:0]          count;
  logic [9:0]          timebase;
  logic                reload;
  logic                flag_set;
  logic                cap_ev;
  logic                cmp_now;
  logic                cmp_hit;
  logic [9:0]          duty_new;
  logic                duty_hit;
  logic                set_q;
  logic [14:0]         gap_q;
  logic                gap_ok_q;

  // ------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------
  function automatic logic addr_ok(input logic [7:0] a);
    return a[1:0] == 2'b00 && a <= pcc_pkg::A_DIR;
  endfunction

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok(paddr);
  assign wr      = psel && penable && pwrite && addr_ok(paddr);
  assign wb      = pwdata[7:0];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      unique case (paddr)
        pcc_pkg::A_MODE: prdata <= {24'h0, 2'b00, mode_q[5:0]};
        pcc_pkg::A_DHI:  prdata <= {24'h0, dhi_q};
        pcc_pkg::A_SHD:  prdata <= {24'h0, shd_q};
        pcc_pkg::A_PER:  prdata <= {24'h0, per_q};
        pcc_pkg::A_TCTL: prdata <= {25'h0, tctl_q};
        pcc_pkg::A_CNT:  prdata <= {24'h0, count};
        pcc_pkg::A_FLAG: prdata <= {30'h0, flag_q};
        pcc_pkg::A_DIR:  prdata <= {31'h0, dir_q};
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------
  assign mode     = mode_q[3:0];
  assign pwm      = pcc_pkg::pcc_is_pwm(mode);
  assign cmp_mode = pcc_pkg::pcc_is_cmp(mode);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_q <= pcc_pkg::MODE_RST;
      per_q  <= pcc_pkg::PER_RST;
      tctl_q <= '0;
      dir_q  <= pcc_pkg::DIR_RST;
    end else if (wr) begin
      unique case (paddr)
        pcc_pkg::A_MODE: mode_q <= {2'b00, wb[5:0]};
        pcc_pkg::A_PER:  per_q  <= wb;
        pcc_pkg::A_TCTL: tctl_q <= wb[6:0];
        pcc_pkg::A_DIR:  dir_q  <= wb[0];
        default:         mode_q <= mode_q;
      endcase
    end
  end

  // ------------------------------------------------------------
  // period timer
  // ------------------------------------------------------------
  pcc_timebase u_tb (
    .clk       (clk),
    .rst_n     (rst_n),
    .tctl      (tctl_q),
    .sleep     (sleep),
    .limit     (per_q),
    .cnt_wr    (wr && paddr == pcc_pkg::A_CNT),
    .cnt_wdata (wb),
    .count     (count),
    .timebase  (timebase),
    .reload    (reload),
    .flag_set  (flag_set)
  );

  pcc_capture u_cap (
    .clk     (clk),
    .rst_n   (rst_n),
    .pin_in  (pin_in),
    .mode    (mode),
    .sleep   (sleep),
    .event_o (cap_ev)
  );

  // ------------------------------------------------------------
  // duty buffering
  // ------------------------------------------------------------
  assign duty_new = {dhi_q, mode_q[5:4]};
  // no match when duty exceeds the period, so the pin just stays
  assign duty_hit = pwm && (timebase == {shd_q, latch_q});

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dhi_q <= pcc_pkg::BYTE_RST;
    end else if (cap_ev) begin
      dhi_q <= capture_timebase[7:0];
    end else if (wr && paddr == pcc_pkg::A_DHI) begin
      dhi_q <= wb;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shd_q   <= pcc_pkg::BYTE_RST;
      latch_q <= 2'b00;
    end else if (pwm && reload) begin
      shd_q   <= dhi_q;
      latch_q <= mode_q[5:4];
    end else if (cap_ev) begin
      shd_q   <= capture_timebase[15:8];
    end else if (!pwm && wr && paddr == pcc_pkg::A_SHD) begin
      shd_q   <= wb;
    end
  end

  // ------------------------------------------------------------
  // compare
  // ------------------------------------------------------------
  assign cmp_now = cmp_mode && !sleep && (capture_timebase == {shd_q, dhi_q});
  assign cmp_hit = cmp_now && !cmp_q;

  always_ff @(posedge clk) begin
    if (!rst_n || mode == pcc_pkg::M_OFF) begin
      cmp_q <= 1'b0;
    end else if (!sleep) begin
      cmp_q <= cmp_now;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timebase_reset <= 1'b0;
      adc_start      <= 1'b0;
    end else begin
      timebase_reset <= cmp_hit && mode == pcc_pkg::M_SPEC;
      adc_start      <= cmp_hit && mode == pcc_pkg::M_SPEC && adc_enable;
    end
  end

  // ------------------------------------------------------------
  // output latch and pin
  // ------------------------------------------------------------
  // pin rises one cycle after the wrap, matching the one-cycle clear latency,
  // so the high time is exactly duty ticks of the time base
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      set_q <= 1'b0;
    end else if (!sleep) begin
      set_q <= pwm && reload && duty_new != 10'h000;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || mode == pcc_pkg::M_OFF) begin
      pin_q <= 1'b0;
    end else if (pwm && !sleep) begin
      // set wins over a duty match in the same cycle
      if (set_q) begin
        pin_q <= 1'b1;
      end else if (duty_hit) begin
        pin_q <= 1'b0;
      end
    end else if (cmp_hit) begin
      unique case (mode)
        pcc_pkg::M_TOG: pin_q <= !pin_q;
        pcc_pkg::M_SET: pin_q <= 1'b1;
        pcc_pkg::M_CLR: pin_q <= 1'b0;
        default:        pin_q <= pin_q;
      endcase
    end
  end

  // reserved codes, capture, software and special modes leave the pin alone
  assign pin_oe  = !dir_q && (pwm || mode == pcc_pkg::M_TOG ||
                   mode == pcc_pkg::M_SET || mode == pcc_pkg::M_CLR);
  assign pin_out = pin_q;

  // ------------------------------------------------------------
  // flags, write one to clear, set wins
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag_q <= pcc_pkg::FLAG_RST;
    end else begin
      if (wr && paddr == pcc_pkg::A_FLAG) begin
        flag_q <= flag_q & ~wb[1:0];
      end
      if (flag_set) begin
        flag_q[pcc_pkg::FL_PERIOD] <= 1'b1;
      end
      if (cap_ev || cmp_hit) begin
        flag_q[pcc_pkg::FL_EVENT] <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_quiet3;
    (!sleep && !wr && tctl_q.period_timer_run && !reload)[*3];
  endsequence

  sequence s_fast_wrap;
    reload && per_q == 8'h00 && tctl_q.prescale_select == pcc_pkg::PS_1;
  endsequence

  // expected clocks between wraps: (limit + 1) * 4 * prescale
  function automatic logic [14:0] gap_len(input logic [7:0] lim, input logic [1:0] ps);
    logic [14:0] base;
    base = {5'h00, lim, 2'b00} + 15'h0004;
    unique case (ps)
      pcc_pkg::PS_1: return base;
      pcc_pkg::PS_4: return {base[12:0], 2'b00};
      default:       return {base[10:0], 4'h0};
    endcase
  endfunction

  // helper: clocks since the last wrap, trusted only across undisturbed periods
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gap_q    <= 15'h0000;
      gap_ok_q <= 1'b0;
    end else if (reload) begin
      gap_q    <= 15'h0001;
      gap_ok_q <= !wr;
    end else begin
      gap_q    <= gap_q + 15'h0001;
      if (wr || sleep || !tctl_q.period_timer_run) begin
        gap_ok_q <= 1'b0;
      end
    end
  end

  AST_WRAP_CLEARS: assert property (@(posedge clk) disable iff (!rst_n)
    reload && !wr |=> count == 8'h00) else $error("counter not cleared on wrap");

  AST_WRAP_SETS_PIN: assert property (@(posedge clk) disable iff (!rst_n)
    pwm && reload && duty_new != 10'h000 && !wr ##1 !sleep |=> pin_q)
    else $error("pin not set on wrap");

  AST_SHADOW_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
    pwm && reload && !wr |=> shd_q == $past(dhi_q)) else $error("shadow not loaded");

  AST_SHADOW_RO: assert property (@(posedge clk) disable iff (!rst_n)
    pwm && !reload && wr |=> $stable(shd_q)) else $error("shadow written in pwm");

  AST_DUTY_CLEARS: assert property (@(posedge clk) disable iff (!rst_n)
    duty_hit && !set_q && !sleep && !wr |=> !pin_q) else $error("pin not cleared on duty");

  AST_PERIOD_FOUR: assert property (@(posedge clk) disable iff (!rst_n)
    s_fast_wrap ##1 s_quiet3 |=> reload) else $error("period length wrong");

  AST_PERIOD_GAP: assert property (@(posedge clk) disable iff (!rst_n)
    reload && gap_ok_q |-> gap_q == gap_len(per_q, tctl_q.prescale_select))
    else $error("wrap spacing wrong");

  AST_SLEEP_FROZEN: assert property (@(posedge clk) disable iff (!rst_n)
    sleep && !wr |=> $stable(count) && $stable(pin_q)) else $error("state moved in sleep");

  AST_OFF_LOW: assert property (@(posedge clk) disable iff (!rst_n)
    mode == pcc_pkg::M_OFF |-> !pin_oe ##1 !pin_q) else $error("latch not low when off");

  AST_SWI_UNDRIVEN: assert property (@(posedge clk) disable iff (!rst_n)
    mode == pcc_pkg::M_SWI |-> !pin_oe) else $error("pin driven in software mode");

  AST_EVENT_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
    cmp_hit && (mode == pcc_pkg::M_SET || mode == pcc_pkg::M_CLR) |=> flag_q[1])
    else $error("event flag not raised");
endmodule

/* File: rtl/pcc_pkg.sv */
// Purpose: shared constants and types for the capture/compare/pwm unit
// Assumes: apb byte addresses, one aligned 32-bit word per register
// Notes:   mode codes, register map, field positions and reset values
package pcc_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int          AW         = 8;
  localparam logic [7:0]  A_MODE     = 8'h00;
  localparam logic [7:0]  A_DHI      = 8'h04;
  localparam logic [7:0]  A_SHD      = 8'h08;
  localparam logic [7:0]  A_PER      = 8'h0C;
  localparam logic [7:0]  A_TCTL     = 8'h10;
  localparam logic [7:0]  A_CNT      = 8'h14;
  localparam logic [7:0]  A_FLAG     = 8'h18;
  localparam logic [7:0]  A_DIR      = 8'h1C;
  localparam logic [7:0]  MODE_RST   = 8'h00;
  localparam logic [7:0]  PER_RST    = 8'hFF;
  localparam logic [7:0]  BYTE_RST   = 8'h00;
  localparam logic [1:0]  FLAG_RST   = 2'h0;
  localparam logic        DIR_RST    = 1'b1;
  localparam int          FL_PERIOD  = 0;
  localparam int          FL_EVENT   = 1;
  // ------------------------------------------------------------
  // mode field codes
  // ------------------------------------------------------------
  localparam logic [3:0]  M_OFF      = 4'h0;
  localparam logic [3:0]  M_TOG      = 4'h2;
  localparam logic [3:0]  M_CFALL    = 4'h4;
  localparam logic [3:0]  M_CRISE    = 4'h5;
  localparam logic [3:0]  M_C4       = 4'h6;
  localparam logic [3:0]  M_C16      = 4'h7;
  localparam logic [3:0]  M_SET      = 4'h8;
  localparam logic [3:0]  M_CLR      = 4'h9;
  localparam logic [3:0]  M_SWI      = 4'hA;
  localparam logic [3:0]  M_SPEC     = 4'hB;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam logic [1:0]  PS_1       = 2'h0;
  localparam logic [1:0]  PS_4       = 2'h1;
  localparam logic [3:0]  PRE_MAX1   = 4'h0;
  localparam logic [3:0]  PRE_MAX4   = 4'h3;
  localparam logic [3:0]  PRE_MAX16  = 4'hF;
  localparam logic [1:0]  PHASE_LAST = 2'h3;
  localparam logic [3:0]  CAP_LAST4  = 4'h3;
  localparam logic [3:0]  CAP_LAST16 = 4'hF;

  typedef struct packed {
    logic [3:0] postscale_select;
    logic       period_timer_run;
    logic [1:0] prescale_select;
  } pcc_tctl_t;

  function automatic logic pcc_is_pwm(input logic [3:0] m);
    return m[3:2] == 2'b11;
  endfunction

  function automatic logic pcc_is_cmp(input logic [3:0] m);
    return (m == M_TOG) || (m[3:2] == 2'b10);
  endfunction
endpackage

/* File: rtl/pcc_timebase.sv */
// Purpose: instruction clock, prescaler, period counter and postscaler
// Assumes: clk is the system clock; sleep comes from same-clock logic
// Notes:   reload pulses on the step where the counter wraps to zero
`timescale 1ns/10ps
module pcc_timebase (
  input  wire logic              clk,        // system clock
  input  wire logic              rst_n,      // sync reset, active low
  input  wire pcc_pkg::pcc_tctl_t tctl,      // period timer control
  input  wire logic              sleep,      // freeze all counting
  input  wire logic [7:0]        limit,      // period limit
  input  wire logic              cnt_wr,     // software counter write
  input  wire logic [7:0]        cnt_wdata,  // counter write data
  output logic      [7:0]        count,      // period counter
  output logic      [9:0]        timebase,   // 10-bit time base
  output logic                   reload,     // counter wraps this cycle
  output logic                   flag_set    // postscaled match
);
  logic [1:0] phase_q;
  logic [3:0] pre_q;
  logic [3:0] post_q;
  logic [3:0] pre_max;
  logic       tick;
  logic       step;

  // ------------------------------------------------------------
  // prescaled instruction tick
  // ------------------------------------------------------------
  always_comb begin
    unique case (tctl.prescale_select)
      pcc_pkg::PS_1: pre_max = pcc_pkg::PRE_MAX1;
      pcc_pkg::PS_4: pre_max = pcc_pkg::PRE_MAX4;
      default:       pre_max = pcc_pkg::PRE_MAX16;
    endcase
  end

  assign tick = (phase_q == pcc_pkg::PHASE_LAST);
  assign step = tick && tctl.period_timer_run && !sleep && (pre_q == pre_max);
  assign reload = step && (count == limit);
  // postscaler only paces the flag, never the counter
  assign flag_set = reload && (post_q == tctl.postscale_select);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_q <= 2'h0;
    end else if (!sleep) begin
      phase_q <= phase_q + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pre_q <= 4'h0;
    end else if (tick && tctl.period_timer_run && !sleep) begin
      pre_q <= (pre_q == pre_max) ? 4'h0 : pre_q + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count <= pcc_pkg::BYTE_RST;
    end else if (cnt_wr) begin
      count <= cnt_wdata;
    end else if (step) begin
      count <= (count == limit) ? pcc_pkg::BYTE_RST : count + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      post_q <= 4'h0;
    end else if (reload) begin
      post_q <= flag_set ? 4'h0 : post_q + 4'h1;
    end
  end

  // low bits: clock phase at 1:1, prescaler bits 1:0 at 1:4, prescaler bits 3:2 otherwise
  always_comb begin
    unique case (tctl.prescale_select)
      pcc_pkg::PS_1: timebase = {count, phase_q};
      pcc_pkg::PS_4: timebase = {count, pre_q[1:0]};
      default:       timebase = {count, pre_q[3:2]};
    endcase
  end
endmodule

/* File: rtl/pcc_capture.sv */
// Purpose: pin edge detection and capture event prescaling
// Assumes: pin_in is asynchronous to clk
// Notes:   edge counter cleared while the unit is off
`timescale 1ns/10ps
module pcc_capture (
  input  wire logic       clk,     // system clock
  input  wire logic       rst_n,   // sync reset, active low
  input  wire logic       pin_in,  // unit pin level, asynchronous
  input  wire logic [3:0] mode,    // unit mode field
  input  wire logic       sleep,   // freeze
  output logic            event_o  // capture event pulse
);
  logic       s1_q;
  logic       s2_q;
  logic       s3_q;
  logic [3:0] edge_q;
  logic       rise;
  logic       fall;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign rise = s2_q && !s3_q && !sleep;
  assign fall = !s2_q && s3_q && !sleep;

  always_ff @(posedge clk) begin
    if (!rst_n || mode == pcc_pkg::M_OFF) begin
      edge_q <= 4'h0;
    end else if (rise) begin
      edge_q <= edge_q + 4'h1;
    end
  end

  always_comb begin
    unique case (mode)
      pcc_pkg::M_CFALL: event_o = fall;
      pcc_pkg::M_CRISE: event_o = rise;
      pcc_pkg::M_C4:    event_o = rise && (edge_q[1:0] == pcc_pkg::CAP_LAST4[1:0]);
      pcc_pkg::M_C16:   event_o = rise && (edge_q == pcc_pkg::CAP_LAST16);
      default:          event_o = 1'b0;
    endcase
  end
endmodule

/* File: tb/pcc_load.sv */
// Purpose: external load on the unit pin
// Assumes: an undriven pin follows ext_lvl from the bench
// Notes:   reports high time and period at each rising pin edge
`timescale 1ns/10ps
module pcc_load (
  input  wire logic        clk,     // system clock
  input  wire logic        pin_out, // unit pin data
  input  wire logic        pin_oe,  // unit pin drive enable
  input  wire logic        ext_lvl, // level seen while undriven
  output logic             pin_in,  // resolved pin level
  output logic      [11:0] hi_len,  // high cycles of last period
  output logic      [11:0] per_len  // cycles of last period
);
  logic        prev_q = 1'b0;
  logic [11:0] hi_q   = 12'h000;
  logic [11:0] per_q  = 12'h000;
  assign pin_in = pin_oe ? pin_out : ext_lvl;
  // counts run free so a stuck pin leaves stale lengths behind
  always_ff @(posedge clk) begin
    prev_q <= pin_in;
    if (pin_in && !prev_q) begin
      hi_len  <= hi_q;
      per_len <= per_q;
      hi_q    <= 12'h001;
      per_q   <= 12'h001;
    end else begin
      hi_q  <= hi_q + {11'h000, pin_in};
      per_q <= per_q + 12'h001;
    end
  end
endmodule

/* File: tb/pcc_top_tb_top.sv */
// Purpose: register-level tests of the capture/compare/pwm unit
// Assumes: zero-wait apb slave, 250 MHz clock
// Notes:   pwm timing is measured by the load model
`timescale 1ns/10ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, (a), (e)); end end
module pcc_top_tb_top;
  logic        clk, rst_n, psel, penable, pwrite, sleep, adc_enable, ext_lvl;
  logic        pready, pslverr, perr, pin_in, pin_out, pin_oe, tb_rst, adc_st;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdata, c;
  logic [15:0] ctb;
  logic [11:0] hi_len, per_len;
  int          n_fail = 0, num_checks = 0, tr_n = 0, ad_n = 0, t0, a0;
  pcc_top uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep(sleep), .capture_timebase(ctb),
    .adc_enable(adc_enable), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .timebase_reset(tb_rst), .adc_start(adc_st));
  pcc_load u_load (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .ext_lvl(ext_lvl), .pin_in(pin_in), .hi_len(hi_len), .per_len(per_len));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    tr_n <= tr_n + int'(tb_rst === 1'b1);
    ad_n <= ad_n + int'(adc_st === 1'b1);
  end
  task automatic wc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdata = prdata;
    perr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    `CHK(rdata, {24'h000000, e})
  endtask
  task automatic rst_chk();
    logic [7:0] ra [8];
    logic [7:0] re [8];
    ra = '{pcc_pkg::A_MODE, pcc_pkg::A_DHI, pcc_pkg::A_SHD, pcc_pkg::A_PER,
      pcc_pkg::A_TCTL, pcc_pkg::A_CNT, pcc_pkg::A_FLAG, pcc_pkg::A_DIR};
    re = '{pcc_pkg::MODE_RST, 8'h00, 8'h00, pcc_pkg::PER_RST, 8'h00, 8'h00,
      {6'h00, pcc_pkg::FLAG_RST}, {7'h00, pcc_pkg::DIR_RST}};
    rst_n <= 1'b0;
    wc(2);
    rst_n <= 1'b1;
    wc(1);
    for (int i = 0; i < 8; i++) rdchk(ra[i], re[i]);
    `CHK(pin_oe, 1'b0)
  endtask
  task automatic pwm_cfg(input logic [1:0] ps, input logic [3:0] post);
    int n;
    wr(pcc_pkg::A_DIR, 8'h01);
    wr(pcc_pkg::A_PER, 8'h03);
    wr(pcc_pkg::A_MODE, 8'h1C);
    wr(pcc_pkg::A_DHI, 8'h02);
    wr(pcc_pkg::A_FLAG, 8'h03);
    wr(pcc_pkg::A_TCTL, {1'b0, post, 1'b0, ps});
    wr(pcc_pkg::A_TCTL, {1'b0, post, 1'b1, ps});
    n = 0;
    do begin
      apb(1'b0, pcc_pkg::A_FLAG, 8'h00);
      n++;
    end while (rdata[pcc_pkg::FL_PERIOD] !== 1'b1 && n < 3000);
    `CHK(rdata[pcc_pkg::FL_PERIOD], 1'b1)
    wr(pcc_pkg::A_DIR, 8'h00);
  endtask
  task automatic meas(input logic [11:0] per, input logic [11:0] hi);
    wc(3 * per + 8);
    `CHK(per_len, per)
    `CHK(hi_len, hi)
  endtask
  task automatic hold_chk(input logic v);
    int bad;
    bad = 0;
    repeat (150) begin
      @(posedge clk);
      if (pin_out !== v) bad++;
    end
    `CHK(bad, 0)
  endtask
  task automatic pulse();
    ext_lvl <= 1'b1;
    wc(6);
    ext_lvl <= 1'b0;
    wc(6);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    logic [3:0] cm [5];
    logic [3:0] pm [4];
    int         np [4];
    cm = '{4'h8, 4'h9, 4'h2, 4'hA, 4'hB};
    pm = '{4'h4, 4'h5, 4'h6, 4'h7};
    np = '{1, 1, 4, 16};
    {rst_n, psel, penable, pwrite, sleep, ext_lvl} = 6'h00;
    adc_enable = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    ctb = 16'h0000;
    @(posedge clk);
    rst_chk();
    apb(1'b0, 8'h20, 8'h00);
    `CHK(perr, 1'b1)
    $display("test reset done");
    pwm_cfg(pcc_pkg::PS_1, 4'h0);
    meas(12'd16, 12'd9);
    rdchk(pcc_pkg::A_SHD, 8'h02);
    wr(pcc_pkg::A_SHD, 8'h55);
    rdchk(pcc_pkg::A_SHD, 8'h02);
    sleep <= 1'b1;
    wr(pcc_pkg::A_DHI, 8'h03);
    rdchk(pcc_pkg::A_SHD, 8'h02);
    sleep <= 1'b0;
    wr(pcc_pkg::A_MODE, 8'h1F);
    meas(12'd16, 12'd13);
    wr(pcc_pkg::A_PER, 8'h00);
    wr(pcc_pkg::A_CNT, 8'h00);
    wc(40);
    pwm_cfg(pcc_pkg::PS_4, 4'hF);
    meas(12'd64, 12'd36);
    $display("test pwm done");
    sleep <= 1'b1;
    wc(2);
    apb(1'b0, pcc_pkg::A_CNT, 8'h00);
    c = rdata;
    t0 = int'(pin_out);
    wc(100);
    apb(1'b0, pcc_pkg::A_CNT, 8'h00);
    `CHK(rdata, c)
    `CHK(int'(pin_out), t0)
    sleep <= 1'b0;
    wc(30);
    apb(1'b0, pcc_pkg::A_CNT, 8'h00);
    `CHK(rdata == c, 1'b0)
    wr(pcc_pkg::A_DHI, 8'h20);
    wc(200);
    hold_chk(1'b1);
    wr(pcc_pkg::A_DHI, 8'h00);
    wr(pcc_pkg::A_MODE, 8'h0C);
    wc(200);
    hold_chk(1'b0);
    wr(pcc_pkg::A_MODE, 8'h00);
    wc(2);
    `CHK({pin_oe, pin_out}, 2'b00)
    rst_chk();
    $display("test sleep and limits done");
    wr(pcc_pkg::A_DIR, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(pcc_pkg::A_MODE, 8'h00);
      wr(pcc_pkg::A_SHD, 8'h00);
      wr(pcc_pkg::A_DHI, 8'h40);
      wr(pcc_pkg::A_MODE, {4'h0, cm[i]});
      wr(pcc_pkg::A_FLAG, 8'h03);
      t0 = tr_n;
      a0 = ad_n;
      ctb <= 16'h0040;
      wc(2);
      ctb <= 16'h0000;
      wc(4);
      `CHK(pin_out, 5'b00101 >> i & 1)
      `CHK(pin_oe, 5'b00111 >> i & 1)
      apb(1'b0, pcc_pkg::A_FLAG, 8'h00);
      `CHK(rdata[pcc_pkg::FL_EVENT], 1'b1)
      `CHK(tr_n - t0 + ad_n - a0, (i == 4) ? 2 : 0)
    end
    $display("test compare done");
    wr(pcc_pkg::A_DIR, 8'h01);
    ctb <= 16'h1234;
    for (int i = 0; i < 4; i++) begin
      wr(pcc_pkg::A_MODE, 8'h00);
      wr(pcc_pkg::A_MODE, {4'h0, pm[i]});
      wr(pcc_pkg::A_FLAG, 8'h03);
      repeat (np[i] - 1) pulse();
      apb(1'b0, pcc_pkg::A_FLAG, 8'h00);
      `CHK(rdata[pcc_pkg::FL_EVENT], 1'b0)
      pulse();
      apb(1'b0, pcc_pkg::A_FLAG, 8'h00);
      `CHK(rdata[pcc_pkg::FL_EVENT], 1'b1)
      rdchk(pcc_pkg::A_SHD, 8'h12);
      rdchk(pcc_pkg::A_DHI, 8'h34);
    end
    $display("test capture done");
    stop_test();
  end
  initial begin
    wc(60000);
    n_fail++;
    stop_test();
  end
endmodule
